// ==== sigcfg_defs.svh ====
// Register offsets, field positions and reset values for the signaling config
`ifndef SIGCFG_DEFS_SVH
`define SIGCFG_DEFS_SVH
`define OFF_HIGH_ADDR_FIRST 8'h04
`define OFF_HIGH_ADDR_SECOND 8'h05
`define OFF_LOW_ADDR_FIRST 8'h06
`define OFF_LOW_ADDR_SECOND 8'h07
`define OFF_CFG_A 8'h09
`define OFF_CFG_B 8'h0A
`define OFF_IRQ_PIN 8'h80
`define OFF_MODE 8'h03
`define RST_HIGH_ADDR_FIRST 8'hFD
`define RST_ADDR_OTHER 8'hFF
`define RST_CFG 8'h00
`define RST_MODE 8'h00
`define CR_MASK 8'hFD
`define BIT_THR_LOW 0
`define BIT_THR_HIGH 1
`define BIT_MF_ALIGN 2
`define BIT_IDLE_FILL 3
`define BIT_SLOT_EN 4
`define BIT_CAS_SYNC 5
`define BIT_RA_INSERT 6
`define BIT_TX_CRC_EXT 2
`define BIT_RX_CRC_PUSH 3
`define BIT_ADDR_PUSH 4
`define BIT_IRQ_LOW 0
`define BIT_IRQ_HIGH 1
`define BIT_SYNC_FREQ 2
`define BIT_INV_ATTACH 0
`define CFG_B_MASK 8'h1C
`define IRQ_PIN_MASK 8'h07
`define FLAG_BYTE 8'h7E
`define IDLE_ONES 8'hFF
// Host command port offsets (AXI4-Lite byte addresses)
`define HOFF_CTRL 8'h00
`define HOFF_WDATA 8'h04
`define HOFF_STATUS 8'h08
`define HOFF_RDATA 8'h0C
`endif

// ==== sigcfg_pkg.sv ====
// Types shared by both ends of the signaling configuration link
package sigcfg_pkg;
  typedef enum logic [1:0] {
    THR_32 = 2'b00,
    THR_16 = 2'b01,
    THR_4 = 2'b10,
    THR_2 = 2'b11
  } threshold_t;
  typedef enum logic [1:0] {
    IRQ_OPEN_DRAIN,
    IRQ_PUSH_LOW,
    IRQ_PUSH_HIGH
  } irq_stage_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ACC = 3'b010,
    H_DONE = 3'b100
  } host_state_t;
endpackage : sigcfg_pkg

// ==== sigcfg_if.sv ====
// Register port between host controller and signaling configuration device
`timescale 1ns/100ps
`default_nettype none
interface sigcfg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  modport device_mp (
    input addr, wdata, wr_en, rd_en,
    output rdata
  );
  modport host_mp (
    output addr, wdata, wr_en, rd_en,
    input rdata
  );
endinterface : sigcfg_if
`default_nettype wire

// ==== addr_match.sv ====
// Shared receive address comparator for all HDLC channels
`timescale 1ns/100ps
`default_nettype none
`include "sigcfg_defs.svh"
module addr_match #(
  parameter int CHANNELS = 1
) (
  input wire logic [7:0] high_first,
  input wire logic [7:0] high_second,
  input wire logic [7:0] low_first,
  input wire logic [7:0] low_second,
  input wire logic [CHANNELS*8-1:0] rx_high,
  input wire logic [CHANNELS*8-1:0] rx_low,
  output logic [CHANNELS-1:0] high_hit,
  output logic [CHANNELS-1:0] low_hit
);
  initial begin
    if (CHANNELS < 1) $error("CHANNELS must be at least 1");
  end
  // One register set serves every channel
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    wire [7:0] hb = rx_high[c*8 +: 8];
    wire [7:0] lb = rx_low[c*8 +: 8];
    assign high_hit[c] = (((hb ^ high_first) & `CR_MASK) == 8'h00)
      || (hb == high_second);
    assign low_hit[c] = (lb == low_first) || (lb == low_second);
  end
endmodule : addr_match
`default_nettype wire

// ==== sigcfg_device.sv ====
// Signaling controller configuration registers and their datapath effects
//
// Summary of operation
// - Inverse attach swaps HDLC to system side
// - Inverse attach swaps receive/transmit slot selects
// - First high address compare ignores command/response bit
// - One address-match set shared by channels
// - Sync frequency bit only in master, no bypass
// - Two bits choose interrupt output stage
// - Remote alarm ORed into CAS Y bit
// - CAS sync mode: standard or two patterns
// - Slot signaling active only when enabled
// - Idle fill: all ones or flags
// - Multiframe align puts first byte first
// - Slot mode raises message end per multiframe
// - Sa-bit mode disregards multiframe align
// - Host keeps sync intervals during transmit
// - Threshold sets accessible receive queue size
// - Host changes threshold only when safe
// - Message-complete clears low byte count bits
// - Address push writes address bytes; SS7 needs
// - CRC push writes CRC then status
// - External CRC: host supplies, device flags
// - No frame length plausibility check
// - Host writes zero to unused bits
// - Masked interrupt blocks pin and global
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sigcfg_defs.svh"
module sigcfg_device #(
  parameter int CHANNELS = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  sigcfg_if.device_mp bus,
  input wire logic [31:0] rx_slot_select,
  input wire logic [31:0] tx_slot_select,
  input wire logic master_select,
  input wire logic clock_bypass_bit,
  input wire logic sa_access_mode,
  input wire logic hdlc_mode_enabled,
  input wire logic multiframe_done,
  input wire logic cas_pattern_ok,
  input wire logic cas_g732_sync,
  input wire logic tx_cas_y_bit,
  input wire logic ext_signaling_y,
  input wire logic use_ext_signaling,
  input wire logic line_rx_data,
  input wire logic system_tx_input,
  input wire logic tx_queue_data,
  input wire logic tx_queue_empty,
  input wire logic rx_message_complete_cmd,
  input wire logic [4:0] rx_byte_count_in,
  input wire logic irq_status,
  input wire logic irq_mask,
  input wire logic [CHANNELS*8-1:0] rx_high,
  input wire logic [CHANNELS*8-1:0] rx_low,
  output logic [CHANNELS-1:0] high_hit,
  output logic [CHANNELS-1:0] low_hit,
  output logic rx_bit_to_queue,
  output logic system_rx_output,
  output logic line_tx_bit,
  output logic [31:0] eff_tx_slots,
  output logic [31:0] eff_rx_slots,
  output logic sync_ref_8k,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic global_irq,
  output logic cas_y_bit,
  output logic cas_aligned,
  output logic mf_start_align,
  output logic rx_message_end_irq,
  output logic [5:0] rx_queue_size,
  output logic [4:0] rx_byte_count,
  output logic address_push,
  output logic rx_crc_push,
  output logic tx_crc_external,
  output logic gen_crc
);
  logic [7:0] high_first_q, high_second_q, low_first_q, low_second_q;
  logic [7:0] cfg_a_q, cfg_b_q, irq_pin_q, mode_q;
  logic [4:0] rbc_q;
  logic cas_seen_q, cas_aligned_q;
  logic [2:0] idle_ptr_q;
  logic mfd_q;
  wire wr = bus.wr_en && clk_en;
  wire inverse_attach = mode_q[`BIT_INV_ATTACH];
  wire slot_signaling_enable = cfg_a_q[`BIT_SLOT_EN];
  wire idle_fill_select = cfg_a_q[`BIT_IDLE_FILL];
  wire tx_multiframe_align = cfg_a_q[`BIT_MF_ALIGN];
  wire cas_sync_mode = cfg_a_q[`BIT_CAS_SYNC];
  wire remote_alarm_insert = cfg_a_q[`BIT_RA_INSERT];
  wire irq_stage_low = irq_pin_q[`BIT_IRQ_LOW];
  wire irq_stage_high = irq_pin_q[`BIT_IRQ_HIGH];
  wire sync_freq_select = irq_pin_q[`BIT_SYNC_FREQ];
  sigcfg_pkg::threshold_t thr;
  assign thr = sigcfg_pkg::threshold_t'({cfg_a_q[`BIT_THR_HIGH],
                                         cfg_a_q[`BIT_THR_LOW]});

  // Register writes; unused bits kept at zero by masking, except in the mode register, which stores all bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_first_q <= `RST_HIGH_ADDR_FIRST;
      high_second_q <= `RST_ADDR_OTHER;
      low_first_q <= `RST_ADDR_OTHER;
      low_second_q <= `RST_ADDR_OTHER;
      cfg_a_q <= `RST_CFG;
      cfg_b_q <= `RST_CFG;
      irq_pin_q <= `RST_CFG;
      mode_q <= `RST_MODE;
    end else if (wr) begin
      case (bus.addr)
        `OFF_HIGH_ADDR_FIRST: high_first_q <= bus.wdata;
        `OFF_HIGH_ADDR_SECOND: high_second_q <= bus.wdata;
        `OFF_LOW_ADDR_FIRST: low_first_q <= bus.wdata;
        `OFF_LOW_ADDR_SECOND: low_second_q <= bus.wdata;
        `OFF_CFG_A: cfg_a_q <= {1'b0, bus.wdata[6:0]};
        `OFF_CFG_B: cfg_b_q <= bus.wdata & `CFG_B_MASK;
        `OFF_IRQ_PIN: irq_pin_q <= bus.wdata & `IRQ_PIN_MASK;
        `OFF_MODE: mode_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  wire [7:0] rd_mux =
    (bus.addr == `OFF_HIGH_ADDR_FIRST) ? high_first_q :
    (bus.addr == `OFF_HIGH_ADDR_SECOND) ? high_second_q :
    (bus.addr == `OFF_LOW_ADDR_FIRST) ? low_first_q :
    (bus.addr == `OFF_LOW_ADDR_SECOND) ? low_second_q :
    (bus.addr == `OFF_CFG_A) ? cfg_a_q :
    (bus.addr == `OFF_CFG_B) ? cfg_b_q :
    (bus.addr == `OFF_IRQ_PIN) ? irq_pin_q :
    (bus.addr == `OFF_MODE) ? mode_q : 8'h00;
  assign bus.rdata = rd_mux;

  addr_match #(.CHANNELS(CHANNELS)) u_match (
    .high_first(high_first_q),
    .high_second(high_second_q),
    .low_first(low_first_q),
    .low_second(low_second_q),
    .rx_high(rx_high),
    .rx_low(rx_low),
    .high_hit(high_hit),
    .low_hit(low_hit)
  );

  // Datapath steering
  assign rx_bit_to_queue = inverse_attach ? system_tx_input
                                          : line_rx_data;
  wire [7:0] flag_pat = `FLAG_BYTE;
  wire idle_bit = idle_fill_select ? flag_pat[idle_ptr_q]
                                   : 1'b1;
  wire tx_bit = tx_queue_empty ? idle_bit : tx_queue_data;
  assign system_rx_output = inverse_attach ? tx_bit : 1'b1;
  assign line_tx_bit = inverse_attach ? 1'b1 : tx_bit;
  wire [31:0] tx_sel = inverse_attach ? rx_slot_select
                                      : tx_slot_select;
  wire [31:0] rx_sel = inverse_attach ? tx_slot_select
                                      : rx_slot_select;
  assign eff_tx_slots = slot_signaling_enable ? tx_sel : 32'h0;
  assign eff_rx_slots = slot_signaling_enable ? rx_sel : 32'h0;
  assign sync_ref_8k = master_select && !clock_bypass_bit
                       && sync_freq_select;

  // Output stage: open drain drives only the asserted low level
  wire irq_active = irq_status && !irq_mask;
  assign global_irq = irq_active;
  assign irq_pin_o = irq_stage_low ? (irq_stage_high ? irq_active
                                                     : !irq_active)
                                   : 1'b0;
  assign irq_pin_oe = irq_stage_low ? 1'b1 : irq_active;

  assign cas_y_bit = remote_alarm_insert
    || (use_ext_signaling ? ext_signaling_y : tx_cas_y_bit);
  assign cas_aligned = cas_aligned_q;
  assign mf_start_align = tx_multiframe_align && !sa_access_mode;
  assign rx_message_end_irq = mfd_q;

  assign rx_queue_size = (thr == sigcfg_pkg::THR_32) ? 6'd32 :
                         (thr == sigcfg_pkg::THR_16) ? 6'd16 :
                         (thr == sigcfg_pkg::THR_4) ? 6'd4 : 6'd2;
  wire [4:0] clr_mask = (thr == sigcfg_pkg::THR_32) ? 5'h1F :
                        (thr == sigcfg_pkg::THR_16) ? 5'h0F :
                        (thr == sigcfg_pkg::THR_4) ? 5'h03 : 5'h01;
  assign rx_byte_count = rbc_q;
  assign address_push = cfg_b_q[`BIT_ADDR_PUSH];
  assign rx_crc_push = cfg_b_q[`BIT_RX_CRC_PUSH];
  assign tx_crc_external = cfg_b_q[`BIT_TX_CRC_EXT];
  // Host-written CRC goes out as is; no length check is made
  assign gen_crc = !cfg_b_q[`BIT_TX_CRC_EXT];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rbc_q <= 5'h00;
      cas_seen_q <= 1'b0;
      cas_aligned_q <= 1'b0;
      idle_ptr_q <= 3'd0;
      mfd_q <= 1'b0;
    end else if (clk_en) begin
      rbc_q <= rx_message_complete_cmd ? (rx_byte_count_in & ~clr_mask)
                                       : rx_byte_count_in;
      idle_ptr_q <= idle_ptr_q + 3'd1;
      mfd_q <= multiframe_done && |eff_rx_slots
               && !hdlc_mode_enabled;
      if (multiframe_done) begin
        cas_seen_q <= cas_pattern_ok;
        cas_aligned_q <= cas_sync_mode ? (cas_pattern_ok && cas_seen_q)
                                       : cas_g732_sync;
      end
    end
  end
endmodule : sigcfg_device
`default_nettype wire

// ==== sigcfg_host.sv ====
// Host end: AXI4-Lite slave whose orders drive the device register port
`timescale 1ns/100ps
`default_nettype none
`include "sigcfg_defs.svh"
module sigcfg_host (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  sigcfg_if.host_mp port,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // CTRL: [7:0] device offset, [8] write, [9] go. Software must mask unused
  // bits itself thresholds and sync intervals change only when idle.
  logic [9:0] ctrl_q;
  logic [7:0] wd_q, rd_q;
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wdat_q;
  sigcfg_pkg::host_state_t st_q;
  wire go_w = aw_q && w_q && !bvalid;
  assign awready = !aw_q && !bvalid;
  assign wready = !w_q && !bvalid;
  assign arready = !rvalid;
  wire busy = st_q != sigcfg_pkg::H_IDLE;
  assign port.addr = ctrl_q[7:0];
  assign port.wdata = wd_q;
  assign port.wr_en = (st_q == sigcfg_pkg::H_ACC) && ctrl_q[8];
  assign port.rd_en = (st_q == sigcfg_pkg::H_ACC) && !ctrl_q[8];
  wire [31:0] rmux = (araddr == `HOFF_CTRL) ? {22'h0, ctrl_q} :
                     (araddr == `HOFF_WDATA) ? {24'h0, wd_q} :
                     (araddr == `HOFF_STATUS) ? {31'h0, busy} :
                     (araddr == `HOFF_RDATA) ? {24'h0, rd_q} : 32'h0;
  wire rd_ok = araddr == `HOFF_CTRL || araddr == `HOFF_WDATA ||
               araddr == `HOFF_STATUS || araddr == `HOFF_RDATA;
  wire wr_ok = awa_q == `HOFF_CTRL || awa_q == `HOFF_WDATA;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wdat_q <= 32'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0;
      ctrl_q <= 10'h000;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
      st_q <= sigcfg_pkg::H_IDLE;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdat_q <= wdata;
      end
      if (go_w) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'b00 : 2'b10;
        if (awa_q == `HOFF_CTRL && wstrb[0] && !busy) begin
          ctrl_q <= wdat_q[9:0];
        end
        if (awa_q == `HOFF_WDATA && wstrb[0]) begin
          wd_q <= wdat_q[7:0];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rmux;
        rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      unique case (st_q)
        sigcfg_pkg::H_IDLE: begin
          if (ctrl_q[9]) begin
            st_q <= sigcfg_pkg::H_ACC;
          end
        end
        sigcfg_pkg::H_ACC: begin
          rd_q <= port.rdata;
          st_q <= sigcfg_pkg::H_DONE;
        end
        sigcfg_pkg::H_DONE: begin
          ctrl_q[9] <= 1'b0;
          st_q <= sigcfg_pkg::H_IDLE;
        end
        default: st_q <= sigcfg_pkg::H_IDLE;
      endcase
    end
  end
endmodule : sigcfg_host
`default_nettype wire

// ==== sigcfg_assertions.sv ====
// Concurrent checks on the register link and the device's config outputs
`timescale 1ns/100ps
`default_nettype none
module sigcfg_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic irq_status,
  input wire logic irq_mask,
  input wire logic global_irq,
  input wire logic irq_pin_oe,
  input wire logic sa_access_mode,
  input wire logic mf_start_align,
  input wire logic rx_message_complete_cmd,
  input wire logic [4:0] rx_byte_count,
  input wire logic [5:0] rx_queue_size,
  input wire logic multiframe_done,
  input wire logic hdlc_mode_enabled,
  input wire logic rx_message_end_irq,
  input wire logic gen_crc,
  input wire logic tx_crc_external
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Size minus one is the set of count bits a completion clears
  wire [4:0] clr_mask = rx_queue_size[4:0] - 5'h01;
  sequence s_complete;
    rx_message_complete_cmd && clk_en;
  endsequence
  sequence s_cleared;
    (rx_byte_count & $past(clr_mask)) == 5'h00;
  endsequence
  property p_count_clear;
    s_complete |=> s_cleared;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count bits kept");
  property p_queue_size;
    rx_queue_size inside {6'h20, 6'h10, 6'h04, 6'h02};
  endproperty
  a_queue_size: assert property (p_queue_size) else $error("bad queue size");
  property p_unused_b;
    rd_en && addr == 8'h0A |-> rdata[7:5] == 3'h0 && rdata[1:0] == 2'h0;
  endproperty
  a_unused_b: assert property (p_unused_b) else $error("cfg b unused set");
  property p_unused_irq;
    rd_en && addr == 8'h80 |-> rdata[7:3] == 5'h00;
  endproperty
  a_unused_irq: assert property (p_unused_irq) else $error("pin unused set");
  property p_irq_global;
    global_irq == (irq_status && !irq_mask);
  endproperty
  a_irq_global: assert property (p_irq_global) else $error("mask ignored");
  property p_irq_release;
    !irq_pin_oe |-> !global_irq;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("pin idle");
  property p_sa_align;
    sa_access_mode |-> !mf_start_align;
  endproperty
  a_sa_align: assert property (p_sa_align) else $error("align in sa");
  property p_crc_gen;
    gen_crc != tx_crc_external;
  endproperty
  a_crc_gen: assert property (p_crc_gen) else $error("crc source");
  property p_msg_end;
    $rose(rx_message_end_irq) |-> $past(multiframe_done) &&
      !$past(hdlc_mode_enabled);
  endproperty
  a_msg_end: assert property (p_msg_end) else $error("stray msg end");
endmodule : sigcfg_assertions
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench: AXI host end joined to the device end
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rx_sel = 32'h0, tx_sel = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, hh, lh;
  logic [16:0] din = 17'h0;
  logic [15:0] rx_high = 16'h0, rx_low = 16'h0;
  logic [4:0] cnt_in = 5'h0, bc, pb;
  logic rxq, sro, ltx, s8k, ipo, ipoe, gi, cy, cal, mfa, mei, ap, rcp, tce, gc;
  logic pm, ca, cs;
  logic ce = 1'b1;
  logic [2:0] ph = 3'h0;
  logic [31:0] etx, erx;
  logic [5:0] qsz;
  logic [7:0] mdl [0:255];
  int n_mismatch = 0, comparisons = 0, seed = 32'h2ace0932, i, j;
  always #4 clk = ~clk;
  // Follows the free idle-fill phase, frozen with the enable
  always @(posedge clk) ph <= !reset_n ? 3'h0 : ce ? ph + 3'h1 : ph;
  sigcfg_if link ();
  sigcfg_host u_sigcfg_host (.clk(clk), .reset_n(reset_n), .clk_en(ce),
    .port(link), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  sigcfg_device #(.CHANNELS(2)) u_sigcfg_device (.clk(clk),
    .reset_n(reset_n), .clk_en(ce), .bus(link), .rx_slot_select(rx_sel),
    .tx_slot_select(tx_sel), .master_select(din[0]),
    .clock_bypass_bit(din[1]), .sa_access_mode(din[2]),
    .hdlc_mode_enabled(din[3]), .multiframe_done(din[4]),
    .cas_pattern_ok(din[5]), .cas_g732_sync(din[6]), .tx_cas_y_bit(din[7]),
    .ext_signaling_y(din[8]), .use_ext_signaling(din[9]),
    .line_rx_data(din[10]), .system_tx_input(din[11]),
    .tx_queue_data(din[12]), .tx_queue_empty(din[13]),
    .rx_message_complete_cmd(din[14]), .rx_byte_count_in(cnt_in),
    .irq_status(din[15]), .irq_mask(din[16]), .rx_high(rx_high),
    .rx_low(rx_low), .high_hit(hh), .low_hit(lh), .rx_bit_to_queue(rxq),
    .system_rx_output(sro), .line_tx_bit(ltx), .eff_tx_slots(etx),
    .eff_rx_slots(erx), .sync_ref_8k(s8k), .irq_pin_o(ipo),
    .irq_pin_oe(ipoe), .global_irq(gi), .cas_y_bit(cy), .cas_aligned(cal),
    .mf_start_align(mfa), .rx_message_end_irq(mei), .rx_queue_size(qsz),
    .rx_byte_count(bc), .address_push(ap), .rx_crc_push(rcp),
    .tx_crc_external(tce), .gen_crc(gc));
  sigcfg_assertions u_sigcfg_assertions (.clk(clk), .reset_n(reset_n),
    .clk_en(ce), .addr(link.addr), .rd_en(link.rd_en), .rdata(link.rdata),
    .irq_status(din[15]), .irq_mask(din[16]), .global_irq(gi),
    .irq_pin_oe(ipoe), .sa_access_mode(din[2]), .mf_start_align(mfa),
    .rx_message_complete_cmd(din[14]), .rx_byte_count(bc),
    .rx_queue_size(qsz), .multiframe_done(din[4]),
    .hdlc_mode_enabled(din[3]), .rx_message_end_irq(mei), .gen_crc(gc),
    .tx_crc_external(tce));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task hang;
    n_mismatch++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 0, 1);
    tally_and_finish();
  endtask : hang
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task mdl_reset;
    for (i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[8'h04] = 8'hFD;
    for (i = 5; i < 8; i++) mdl[i] = 8'hFF;
  endtask : mdl_reset
  task axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (r === 2'h3) hang();
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (r === 2'h3) hang();
  endtask : axi_rd
  // The host is polled rather than waited on by count: its latency may grow
  task dev_cmd(input logic wr, input logic [7:0] off);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    axi_wr(8'h00, {22'h0, 1'b1, wr, off}, r);
    for (n = 0; n < 20; n++) begin
      axi_rd(8'h08, st, r);
      if (st[0] === 1'b0) break;
    end
    if (n == 20) hang();
  endtask : dev_cmd
  task dev_wr(input logic [7:0] off, input logic [7:0] v);
    logic [1:0] r;
    axi_wr(8'h04, {24'h0, v}, r);
    dev_cmd(1'b1, off);
    case (off)
      8'h03, 8'h04, 8'h05, 8'h06, 8'h07: mdl[off] = v;
      8'h09: mdl[off] = v & 8'h7F;
      8'h0A: mdl[off] = v & 8'h1C;
      8'h80: mdl[off] = v & 8'h07;
      default: ;
    endcase
  endtask : dev_wr
  task dev_rd_chk(input logic [7:0] off);
    logic [31:0] d;
    logic [1:0] r;
    dev_cmd(1'b0, off);
    axi_rd(8'h0C, d, r);
    check(d[7:0], mdl[off]);
  endtask : dev_rd_chk
  task read_all;
    foreach (mdl[k]) if (k inside {3, 4, 5, 6, 7, 9, 10, 128, 32}) dev_rd_chk(k);
  endtask : read_all
  // Registered outputs expected after the coming edge
  task predict;
    logic [7:0] a;
    logic [4:0] mk;
    logic [31:0] er;
    a = mdl[8'h09];
    mk = a[1] ? (a[0] ? 5'h01 : 5'h03) : (a[0] ? 5'h0F : 5'h1F);
    er = a[4] ? (mdl[8'h03][0] ? tx_sel : rx_sel) : 32'h0;
    if (ce) begin
      pb = din[14] ? cnt_in & ~mk : cnt_in;
      pm = din[4] && er != 32'h0 && !din[3];
      if (din[4]) begin
        ca = a[5] ? din[5] && cs : din[6];
        cs = din[5];
      end
    end
  endtask : predict
  task chk_outs;
    logic [7:0] a, b, ip;
    logic inv, en, act, txb;
    logic [7:0] flag;
    logic [4:0] mk;
    int c;
    a = mdl[8'h09]; b = mdl[8'h0A]; ip = mdl[8'h80]; inv = mdl[8'h03][0];
    en = a[4]; act = din[15] & ~din[16];
    mk = a[1] ? (a[0] ? 5'h01 : 5'h03) : (a[0] ? 5'h0F : 5'h1F);
    check(etx, en ? (inv ? rx_sel : tx_sel) : 32'h0);
    check(erx, en ? (inv ? tx_sel : rx_sel) : 32'h0);
    check(rxq, inv ? din[11] : din[10]);
    flag = 8'h7E;
    txb = din[13] ? (a[3] ? flag[ph] : 1'b1) : din[12];
    check(inv ? sro : ltx, txb);
    check(inv ? ltx : sro, 1'b1);
    check(s8k, din[0] & ~din[1] & ip[2]);
    check(gi, act);
    check({ipoe, ipo}, ip[0] ? {1'b1, ip[1] ~^ act} : {act, 1'b0});
    check(cy, a[6] | (din[9] ? din[8] : din[7]));
    check(mfa, a[2] & ~din[2]);
    check(qsz, mk + 6'h01);
    check(bc, pb);
    check(mei, pm);
    check(cal, ca);
    check({ap, rcp, tce, gc}, {b[4], b[3], b[2], ~b[2]});
    for (c = 0; c < 2; c++) begin
      check(hh[c], (rx_high[c*8+:8] & 8'hFD) == (mdl[4] & 8'hFD) ||
        rx_high[c*8+:8] == mdl[5]);
      check(lh[c], rx_low[c*8+:8] == mdl[6] || rx_low[c*8+:8] == mdl[7]);
    end
    predict();
  endtask : chk_outs
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] h [0:3];
    mdl_reset();
    pb = 5'h0; pm = 1'b0; ca = 1'b0; cs = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    read_all();
    $display("test reset values done");
    axi_wr(8'h10, 32'h5, r);
    check(r, 2'b10);
    axi_rd(8'h14, d, r);
    check(r, 2'b10);
    foreach (mdl[k]) if (k inside {9, 10, 128, 32}) dev_wr(k, 8'hFF);
    read_all();
    $display("test refusals and unused bits done");
    for (i = 0; i < 24; i++) begin
      dev_wr(8'h03, {7'h0, 1'($random(seed))});
      foreach (mdl[k]) if (k inside {4, 5, 6, 7, 9, 10, 128})
        dev_wr(k, 8'($random(seed)));
      h[0] = mdl[4] ^ 8'h02; h[1] = mdl[5]; h[2] = mdl[4] ^ 8'h01;
      // Inputs were held through the writes, so the state has settled
      predict();
      predict();
      for (j = 0; j < 8; j++) begin
        @(posedge clk);
        h[3] = 8'($random(seed));
        din <= 17'($random(seed));
        rx_sel <= $random(seed);
        tx_sel <= $random(seed);
        cnt_in <= 5'($random(seed));
        ce <= |2'($random(seed));
        rx_high <= {h[2'($random(seed))], h[2'($random(seed))]};
        rx_low <= {mdl[6 + j % 2], 8'($random(seed))};
        @(negedge clk);
        chk_outs();
      end
      @(posedge clk);
      ce <= 1'b1;
    end
    $display("test random config done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    mdl_reset();
    read_all();
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
